// *** iot_regs.vh ***
/*
 * Register map, field positions, reset values and timing counts for the
 * internal oscillator trim and pin-mode block.
 * Assumes inclusion by its bare name from the block's single design file.
 */
// Behaviour
// - Clock-out mode: out pin gives clock over four; in pin is port A bit seven.
// - Full-I/O mode gives osc in to port A bit seven, osc out to bit six.
// - Trim writes shift frequency in constant steps across plus or minus 12.5 percent.
// - Slow RC clock reaches new trimmed frequency within eight of its cycles.
// - Fast oscillator settles at new trimmed frequency within one millisecond.
// - Processor keeps running, never stalled, while frequency moves to new trim.
// - No status flag shows that a trim-driven frequency shift has finished.
// - Slow-RC clients follow the trimmed frequency, not the nominal 31.25 kHz.
`ifndef IOT_REGS_VH
`define IOT_REGS_VH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define IOT_OSC_TRIM_ADDR   32'h0000_0090
`define IOT_MODE_CTRL_ADDR  32'h0000_0094
`define IOT_OSC_TRIM_RESET  6'h00
`define IOT_TRIM_W          6
`define IOT_MODE_RESET      2'h0
`define IOT_MODE_PLAIN      2'h0
`define IOT_MODE_CLKOUT     2'h1
`define IOT_MODE_FULLIO     2'h2

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define IOT_CLK_MHZ         200
`define IOT_FAST_SETTLE_US  1000
`define IOT_FAST_SETTLE_CYC (`IOT_FAST_SETTLE_US * `IOT_CLK_MHZ)
`define IOT_SLOW_SETTLE_CYC 8
`define IOT_SPAN_PERMILLE   125

`endif

// *** iot_osc_trim.v ***
/*
 * Internal oscillator trim and pin-mode block: AHB-Lite register slave,
 * trim code slewing for the fast and slow internal clocks, Fosc/4 output and
 * oscillator pin release to port A.
 * Assumes a single-master AHB-Lite bus where this slave's HREADYOUT is HREADY,
 * and an analogue oscillator that takes a settled trim word for each source.
 */
`timescale 1ns/1ps
`include "iot_regs.vh"

module iot_osc_trim #(
  parameter FAST_SETTLE_CYC = `IOT_FAST_SETTLE_CYC
) (
  // Clock and reset
  input  wire        CLK_I,
  input  wire        SYS_RST_I,
  // AHB-Lite slave
  input  wire        HSEL_I,
  input  wire [31:0] HADDR_I,
  input  wire [1:0]  HTRANS_I,
  input  wire        HWRITE_I,
  input  wire [2:0]  HSIZE_I,
  input  wire [31:0] HWDATA_I,
  input  wire        HREADY_I,
  output wire [31:0] HRDATA_O,
  output wire        HREADYOUT_O,
  output wire        HRESP_O,
  // Slow RC clock tick (one pulse per slow RC cycle)
  input  wire        SLOW_RC_TICK_I,
  // Trim words applied to the oscillators
  output wire [5:0]  FAST_TRIM_O,
  output wire [5:0]  SLOW_TRIM_O,
  // Oscillator pins as port A bits
  input  wire        OSC_IN_PIN_I,
  input  wire        OSC_OUT_PIN_I,
  input  wire [1:0]  PORT_A_OUT_I,
  input  wire [1:0]  PORT_A_OE_I,
  output wire        OSC_OUT_PIN_O,
  output wire        OSC_OUT_PIN_OE_O,
  output wire        OSC_IN_PIN_O,
  output wire        OSC_IN_PIN_OE_O,
  output wire [1:0]  PORT_A_IN_O,
  output wire [1:0]  PORT_A_EN_O
);

  // --------------------------------------------------------------------------
  // Bus address phase capture
  // --------------------------------------------------------------------------
  reg        dp_write;
  reg        dp_read;
  reg [31:0] dp_addr;
  reg [5:0]  trim_code;
  reg [1:0]  pin_mode;
  reg [31:0] rdata;
  reg [5:0]  fast_trim;
  reg [5:0]  slow_trim;
  reg [31:0] fast_cnt;
  reg [3:0]  slow_cnt;
  reg [5:0]  trim_prev;
  reg [1:0]  fosc_div;
  reg        clk_out;
  wire       take = HSEL_I & HTRANS_I[1] & HREADY_I;
  // A fresh code restarts both settle windows
  wire       trim_moved = (trim_code != trim_prev);
  // Forward a write still in its data phase to a read behind it
  wire       fwd_trim = dp_write & (dp_addr == `IOT_OSC_TRIM_ADDR);
  wire       fwd_mode = dp_write & (dp_addr == `IOT_MODE_CTRL_ADDR);

  // Slave never waits: zero wait states, always OKAY
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;
  assign HRDATA_O    = rdata;

  // Latch the address phase so the write lands in the data phase
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      dp_write <= 1'b0;
      dp_read  <= 1'b0;
      dp_addr  <= 32'h0000_0000;
    end else begin
      dp_write <= take & HWRITE_I;
      dp_read  <= take & ~HWRITE_I;
      dp_addr  <= HADDR_I;
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  // Only six trim bits exist, so write data bits 31:6 drop on write
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      trim_code <= `IOT_OSC_TRIM_RESET;
      pin_mode  <= `IOT_MODE_RESET;
    end else if (dp_write) begin
      if (dp_addr == `IOT_OSC_TRIM_ADDR)
        trim_code <= HWDATA_I[5:0];
      if (dp_addr == `IOT_MODE_CTRL_ADDR)
        pin_mode  <= HWDATA_I[1:0];
    end
  end

  // Read data registered in the address phase; unmapped reads give zero.
  // No settle-done bit is offered: software cannot see the slew end.
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rdata <= 32'h0000_0000;
    end else if (take & ~HWRITE_I) begin
      if (HADDR_I == `IOT_OSC_TRIM_ADDR)
        rdata <= {26'h000_0000, fwd_trim ? HWDATA_I[5:0] : trim_code};
      else if (HADDR_I == `IOT_MODE_CTRL_ADDR)
        rdata <= {30'h0000_0000, fwd_mode ? HWDATA_I[1:0] : pin_mode};
      else
        rdata <= 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------------
  // Trim slewing
  // --------------------------------------------------------------------------
  // The code is two's complement: signed step k moves frequency by
  // k/32 of 12.5 percent, a constant step across the range.
  // The fast source takes a new code after its settle window; the
  // window restarts on every new code so only a stable code is applied.
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      fast_trim <= `IOT_OSC_TRIM_RESET;
      fast_cnt  <= 32'h0000_0000;
      trim_prev <= `IOT_OSC_TRIM_RESET;
    end else begin
      trim_prev <= trim_code;
      if (fast_trim == trim_code) begin
        fast_cnt  <= 32'h0000_0000;
      end else if (trim_moved) begin
        fast_cnt  <= 32'h0000_0000;
      end else if (fast_cnt >= FAST_SETTLE_CYC - 1) begin
        fast_trim <= trim_code;
        fast_cnt  <= 32'h0000_0000;
      end else begin
        fast_cnt  <= fast_cnt + 32'h0000_0001;
      end
    end
  end

  // Slow RC code lands on the eighth slow tick after a change
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      slow_trim <= `IOT_OSC_TRIM_RESET;
      slow_cnt  <= 4'h0;
    end else if (slow_trim == trim_code) begin
      slow_cnt  <= 4'h0;
    end else if (trim_moved) begin
      slow_cnt  <= {3'h0, SLOW_RC_TICK_I};         // A tick on the change cycle still counts
    end else if (SLOW_RC_TICK_I) begin
      if (slow_cnt >= `IOT_SLOW_SETTLE_CYC - 1) begin
        slow_trim <= trim_code;
        slow_cnt  <= 4'h0;
      end else begin
        slow_cnt  <= slow_cnt + 4'h1;
      end
    end
  end

  // Watchdog, clock monitor and peripherals read the trimmed slow clock.
  // Nothing here holds the CPU: slewing runs beside execution.
  assign FAST_TRIM_O = fast_trim;
  assign SLOW_TRIM_O = slow_trim;

  // --------------------------------------------------------------------------
  // Pin modes
  // --------------------------------------------------------------------------
  // Divide by four: output toggles every second clock
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      fosc_div <= 2'h0;
      clk_out  <= 1'b0;
    end else begin
      fosc_div <= fosc_div + 2'h1;
      if (fosc_div[0])
        clk_out <= ~clk_out;
    end
  end

  // In plain mode the pins belong to the oscillator and are not driven
  wire mode_co = (pin_mode == `IOT_MODE_CLKOUT);
  wire mode_io = (pin_mode == `IOT_MODE_FULLIO);
  wire a7_en   = mode_co | mode_io;

  assign OSC_IN_PIN_O     = PORT_A_OUT_I[1];
  assign OSC_IN_PIN_OE_O  = a7_en & PORT_A_OE_I[1];
  assign OSC_OUT_PIN_O    = mode_co ? clk_out : PORT_A_OUT_I[0];
  assign OSC_OUT_PIN_OE_O = mode_co | (mode_io & PORT_A_OE_I[0]);
  assign PORT_A_IN_O      = {OSC_IN_PIN_I & a7_en, OSC_OUT_PIN_I & mode_io};
  assign PORT_A_EN_O      = {a7_en, mode_io};

endmodule // iot_osc_trim

// *** iot_osc_trim_props.sv ***
/* Port-level properties of the oscillator trim block.
   Assumes a bind onto iot_osc_trim, one clock, FAST_SETTLE_CYC of 12 or more. */
`timescale 1ns/1ps
module iot_osc_trim_props #(parameter FAST_SETTLE_CYC = 20) (
  // Clock, reset and bus
  input wire        CLK_I, SYS_RST_I, HSEL_I, HWRITE_I, HREADY_I, HREADYOUT_O, HRESP_O,
  input wire [31:0] HADDR_I, HRDATA_O,
  input wire [1:0]  HTRANS_I,
  // Trim and pins
  input wire        SLOW_RC_TICK_I, OSC_IN_PIN_I, OSC_OUT_PIN_I,
  input wire        OSC_OUT_PIN_O, OSC_OUT_PIN_OE_O, OSC_IN_PIN_O, OSC_IN_PIN_OE_O,
  input wire [5:0]  FAST_TRIM_O, SLOW_TRIM_O,
  input wire [1:0]  PORT_A_OUT_I, PORT_A_OE_I, PORT_A_IN_O, PORT_A_EN_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // --------------------------------------------------------------------------
  // Sequences
  // --------------------------------------------------------------------------
  sequence s_trim_wr;
    HSEL_I && HTRANS_I[1] && HWRITE_I && HREADY_I && HADDR_I == 32'h0000_0090;
  endsequence
  sequence s_div_rise;
    $rose(OSC_OUT_PIN_O) && PORT_A_EN_O == 2'b10 && $past(PORT_A_EN_O) == 2'b10;
  endsequence
  // Bus never stalls, so the processor runs on during a shift
  property p_ready; HREADYOUT_O && !HRESP_O; endproperty
  a_ready: assert property (p_ready) else $error("bus stalled or errored");
  // A mode change ends the divider check early
  property p_div4; s_div_rise |-> OSC_OUT_PIN_OE_O ##4 ($rose(OSC_OUT_PIN_O) || PORT_A_EN_O != 2'b10); endproperty
  a_div4: assert property (p_div4) else $error("clock out is not a divide by four");
  property p_in_pin; PORT_A_EN_O[1] |-> OSC_IN_PIN_O == PORT_A_OUT_I[1] && OSC_IN_PIN_OE_O == PORT_A_OE_I[1];
  endproperty
  a_in_pin: assert property (p_in_pin) else $error("in pin not driven as port bit");
  property p_full_out; PORT_A_EN_O == 2'b11 |-> {OSC_OUT_PIN_O, OSC_OUT_PIN_OE_O} == {PORT_A_OUT_I[0], PORT_A_OE_I[0]};
  endproperty
  a_full_out: assert property (p_full_out) else $error("out pin not driven as port bit");
  property p_gate; PORT_A_IN_O == ({OSC_IN_PIN_I, OSC_OUT_PIN_I} & PORT_A_EN_O); endproperty
  a_gate: assert property (p_gate) else $error("port input gating wrong");
  property p_upper; HRDATA_O[31:6] == 26'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits not zero");
  // Fast trim must not jump within the settle window
  property p_fast_hold; s_trim_wr |-> ##3 $stable(FAST_TRIM_O) [*8]; endproperty
  a_fast_hold: assert property (p_fast_hold) else $error("fast trim moved early");
  property p_slow_tick; (!SLOW_RC_TICK_I) [*3] |-> $stable(SLOW_TRIM_O); endproperty
  a_slow_tick: assert property (p_slow_tick) else $error("slow trim moved without a tick");
endmodule // iot_osc_trim_props

// *** iot_osc_trim_test.sv ***
/* Self-checking bench for the oscillator trim block over AHB-Lite.
   Assumes iot_osc_trim and its props checker are compiled alongside. */
`timescale 1ns/1ps
module iot_osc_trim_test;
  localparam int FS = 20; // Short settle window keeps the run brief
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0, tick = 0, pin_in = 0, pin_out = 0, p;
  logic [1:0]  htrans = 0, pa_out = 0, pa_oe = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  wire [31:0] hrdata;
  wire hrdy, hresp, out_o, out_oe, in_o, in_oe;
  wire [5:0] ftrim, strim;
  wire [1:0] pa_in, pa_en;
  int fails = 0, n_tests = 0, k;
  always #2.5 clk = ~clk;
  iot_osc_trim #(.FAST_SETTLE_CYC(FS)) i_dut (.CLK_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hrdy), .HRDATA_O(hrdata),
    .HREADYOUT_O(hrdy), .HRESP_O(hresp), .SLOW_RC_TICK_I(tick), .FAST_TRIM_O(ftrim), .SLOW_TRIM_O(strim),
    .OSC_IN_PIN_I(pin_in), .OSC_OUT_PIN_I(pin_out), .PORT_A_OUT_I(pa_out), .PORT_A_OE_I(pa_oe),
    .OSC_OUT_PIN_O(out_o), .OSC_OUT_PIN_OE_O(out_oe), .OSC_IN_PIN_O(in_o), .OSC_IN_PIN_OE_O(in_oe),
    .PORT_A_IN_O(pa_in), .PORT_A_EN_O(pa_en));
  task end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      $display("BAD at %0t: got %h expected %h", $time, g, e);
      fails++;
    end
  endtask
  // Bounded wait for hready at the next edges
  task rdy;
    int i;
    i = 0;
    @(posedge clk);
    while (hrdy !== 1'b1) begin
      i++;
      if (i > 50) begin fails++; end_sim; end
      @(posedge clk);
    end
  endtask
  task bus(input logic w, input logic [31:0] a, d);
    hsel <= 1; htrans <= 2'b10; haddr <= a; hwrite <= w;
    rdy;
    hsel <= 0; htrans <= 2'b00; hwdata <= d;
    rdy;
    rd = hrdata;
  endtask
  task ticks(input int n);
    repeat (n) begin tick <= 1; @(posedge clk); tick <= 0; @(posedge clk); end
  endtask
  task t_regs;
    bus(0, 32'h0000_0090, 0); chk(rd, 0);
    bus(1, 32'h0000_0098, 32'hFFFF_FFFF); bus(0, 32'h0000_0098, 0); chk(rd, 0);
    for (k = 0; k < 4; k++) begin
      bus(1, 32'h0000_0090, 32'h0000_00DF + k); bus(0, 32'h0000_0090, 0);
      chk(rd, (32'h0000_00DF + k) & 32'h0000_003F);
    end
    bus(1, 32'h0000_0090, 0); ticks(9); repeat (FS + 5) @(posedge clk);
  endtask
  task t_settle;
    bus(1, 32'h0000_0090, 32'h0000_0020); chk(32'(ftrim), 0);
    ticks(7); chk(32'(strim), 0); chk(32'(ftrim), 0);
    ticks(1); repeat (2) @(posedge clk); chk(32'(strim), 32'h0000_0020);
    k = 0;
    while (ftrim !== 6'h20 && k < 30) begin @(posedge clk); k++; end
    chk(32'(ftrim), 32'h0000_0020);
  endtask
  task t_modes;
    pa_out <= 2'b10; pa_oe <= 2'b11; pin_in <= 1; pin_out <= 1;
    bus(1, 32'h0000_0094, 1); @(posedge clk); p = out_o; k = 0;
    repeat (16) begin @(posedge clk); if (out_o && !p) k++; p = out_o; end
    chk(k, 4); chk({pa_en, pa_in, out_oe, in_o, in_oe}, 7'b1010111);
    bus(1, 32'h0000_0094, 2); @(posedge clk);
    chk({pa_en, pa_in, out_o, out_oe, in_o, in_oe}, 8'b1111_0111);
    bus(1, 32'h0000_0094, 3); @(posedge clk);
    chk({pa_en, out_oe, in_oe}, 0);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    t_regs; t_settle; t_modes;
    end_sim;
  end
endmodule // iot_osc_trim_test
bind iot_osc_trim iot_osc_trim_props #(.FAST_SETTLE_CYC(FAST_SETTLE_CYC)) i_props (.*);
